// file: hdl/winding_phase_compensator.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - the phase reference winding gets zero shift; it is passed through unchanged unless grounded inside the zone
// - reference is the lowest-index non-wye winding (delta, zigzag or conn code 3) when any exists
// - with only wye windings, winding one is the reference
// - angle is reference minus winding for abc, winding minus reference for acb
// - all compensation completes before results are presented downstream
// - odd thirty-degree codes give one-over-root-three phase differences
// - even codes outside zone give rotated or negated phases
// - even codes inside zone also remove one third of the phase sum
// - zero sequence removal only for windings grounded inside the zone
// - raw phase currents in, compensated phase currents out, per winding
module winding_phase_compensator
  import wpc_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              in_valid,
  input  wire all_in_t           in_data,
  output logic                   out_valid,
  output var  all_out_t          out_data,
  output logic [REF_W-1:0]       ref_wdg
);

  // configuration state
  logic                 rot_r;
  logic                 en_r;
  wcfg_t [NW-1:0]       wcfg_r;
  logic                 cfg_err_r;
  logic [31:0]          frame_cnt_r;

  // bus state
  logic                 wr_pend_r;
  logic [7:0]           wr_addr_r;
  logic                 hreadyout_r;
  logic [31:0]          hrdata_r;

  // datapath state
  logic                     s1_valid_r;
  all_in_t                  s1_data_r;
  logic [NW-1:0][CODE_W-1:0] s1_code_r;
  logic [NW-1:0]            s1_gnd_r;
  logic                     out_valid_r;
  all_out_t                 out_data_r;
  logic [REF_W-1:0]         ref_r;

  // combinational helpers
  logic [REF_W-1:0]          ref_nxt;
  logic                      all_wye;
  logic [NW-1:0][CODE_W-1:0] comp_code;
  all_out_t                  mixed;
  logic                      addr_ok;
  logic                      wr_go;
  logic                      err_set;
  logic [31:0]               rd_word;

  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;
  assign ref_wdg   = ref_r;

  // address phase of a transfer addressed to us
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_go   = wr_pend_r;

  // reference: scan from the top so the lowest non-wye index wins
  always_comb begin
    ref_nxt = '0;
    all_wye = 1'b1;
    for (int w = NW - 1; w >= 0; w--) begin
      if (wcfg_r[w].conn != CONN_WYE) begin
        ref_nxt = REF_W'(w);
        all_wye = 1'b0;
      end
    end
  end

  // compensation code per winding, modulo twelve steps of lag
  always_comb begin
    for (int w = 0; w < NW; w++) begin
      logic [CODE_W:0] d;
      d = '0;
      if (rot_r) begin
        d = {1'b0, wcfg_r[w].code} + {1'b0, NCODE} - {1'b0, wcfg_r[ref_nxt].code};
      end else begin
        d = {1'b0, wcfg_r[ref_nxt].code} + {1'b0, NCODE} - {1'b0, wcfg_r[w].code};
      end
      if (d >= {1'b0, NCODE}) begin
        d = d - {1'b0, NCODE};
      end
      // the reference winding's own difference is always zero
      comp_code[w] = CODE_W'(d);
    end
  end

  // word read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = '0;
    case (haddr[7:0] & ADDR_MSK)
      CTRL_OFS: begin
        rd_word[CTRL_ROT] = rot_r;
        rd_word[CTRL_EN]  = en_r;
      end
      STAT_OFS: begin
        rd_word[REF_W-1:0]   = ref_r;
        rd_word[STAT_ALLWYE] = all_wye;
        rd_word[STAT_CODES +: NW*CODE_W] = comp_code;
        rd_word[STAT_ERR]    = cfg_err_r;
      end
      CNT_OFS: begin
        rd_word = frame_cnt_r;
      end
      default: begin
        for (int w = 0; w < NW; w++) begin
          if (haddr[7:0] == WCFG_OFS + 8'(w) * WCFG_STEP) begin
            rd_word[CODE_W-1:0]       = wcfg_r[w].code;
            rd_word[WCFG_CONN +: 2]   = wcfg_r[w].conn;
            rd_word[WCFG_GND]         = wcfg_r[w].gnd;
          end
        end
      end
    endcase
  end

  // zero wait states, so ready only leaves reset once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  // capture a write's address phase; data follows next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok && hwrite) begin
        wr_addr_r <= haddr[7:0];
      end
    end
  end

  // read data is loaded at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (addr_ok && !hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rot_r <= ROT_RST;
      en_r  <= EN_RST;
    end else if (wr_go && wr_addr_r == CTRL_OFS) begin
      rot_r <= hwdata[CTRL_ROT];
      en_r  <= hwdata[CTRL_EN];
    end
  end

  // winding settings; an angle code past eleven is refused whole
  assign err_set = wr_go && (wr_addr_r >= WCFG_OFS)
                && (wr_addr_r < WCFG_OFS + 8'(NW) * WCFG_STEP)
                && (hwdata[CODE_W-1:0] > LAST_CODE);

  for (genvar w = 0; w < NW; w++) begin : g_cfg
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        wcfg_r[w] <= '0;
      end else if (wr_go && !err_set && wr_addr_r == WCFG_OFS + 8'(w) * WCFG_STEP) begin
        wcfg_r[w].code <= hwdata[CODE_W-1:0];
        wcfg_r[w].conn <= hwdata[WCFG_CONN +: 2];
        wcfg_r[w].gnd  <= hwdata[WCFG_GND];
      end
    end
  end

  // sticky setting error, write one to clear; a new error wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_err_r <= 1'b0;
    end else if (err_set) begin
      cfg_err_r <= 1'b1;
    end else if (wr_go && wr_addr_r == STAT_OFS && hwdata[STAT_ERR]) begin
      cfg_err_r <= 1'b0;
    end
  end

  // reference shown on a port and in status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_r <= '0;
    end else begin
      ref_r <= ref_nxt;
    end
  end

  // stage one: sample currents with the settings they belong to
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_valid_r <= 1'b0;
      s1_data_r  <= '0;
      s1_code_r  <= '0;
      s1_gnd_r   <= '0;
    end else begin
      s1_valid_r <= in_valid && en_r;
      if (in_valid && en_r) begin
        s1_data_r <= in_data;
        s1_code_r <= comp_code;
        for (int w = 0; w < NW; w++) begin
          s1_gnd_r[w] <= wcfg_r[w].gnd;
        end
      end
    end
  end

  // one combiner per winding
  for (genvar w = 0; w < NW; w++) begin : g_mix
    phase_mix u_mix (
      .x           (s1_data_r[w]),
      .code        (s1_code_r[w]),
      .gnd_in_zone (s1_gnd_r[w]),
      .y           (mixed[w])
    );
  end

  // stage two: every winding lands together under one strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else begin
      out_valid_r <= s1_valid_r;
      if (s1_valid_r) begin
        out_data_r <= mixed;
      end
    end
  end

  // count of delivered result sets, wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cnt_r <= '0;
    end else if (out_valid_r) begin
      frame_cnt_r <= frame_cnt_r + 32'h1;
    end
  end

  // hsize is not checked: every register is a whole word
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:8], htrans[0]};

endmodule
`default_nettype wire

// file: pkg/wpc_pkg.sv
package wpc_pkg;

  // sizes of the datapath
  localparam int NW     = 4;   // windings
  localparam int NPH    = 3;   // phases a, b, c
  localparam int IN_W   = 16;  // input component width
  localparam int OUT_W  = 18;  // output width, room for 1/sqrt3 sums
  localparam int SUM_W  = 19;
  localparam int COEF_W = 17;
  localparam int PROD_W = SUM_W + COEF_W;
  localparam int FRAC   = 15;  // coefficient fraction bits
  localparam int CODE_W = 4;   // angle code, 30 degree steps of lag
  localparam int REF_W  = 2;

  // q1.15 coefficients
  localparam logic signed [COEF_W-1:0] INV_SQRT3 = 17'sh049e7;
  localparam logic signed [COEF_W-1:0] ONE_THIRD = 17'sh02aab;

  localparam logic [CODE_W-1:0] NCODE     = 4'hc;
  localparam logic [CODE_W-1:0] LAST_CODE = 4'hb;

  // winding connection types
  localparam logic [1:0] CONN_WYE    = 2'h0;
  localparam logic [1:0] CONN_DELTA  = 2'h1;
  localparam logic [1:0] CONN_ZIGZAG = 2'h2;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] CNT_OFS   = 8'h08;
  localparam logic [7:0] WCFG_OFS  = 8'h10;
  localparam logic [7:0] WCFG_STEP = 8'h04;
  localparam logic [7:0] ADDR_MSK  = 8'hff;

  // field positions
  localparam int CTRL_ROT    = 0;  // 0 abc, 1 acb
  localparam int CTRL_EN     = 1;
  localparam int WCFG_CONN   = 4;
  localparam int WCFG_GND    = 6;
  localparam int STAT_ALLWYE = 2;
  localparam int STAT_CODES  = 4;
  localparam int STAT_ERR    = 24;

  // reset values
  localparam logic       ROT_RST = 1'b0;
  localparam logic       EN_RST  = 1'b1;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;

  typedef struct packed {
    logic signed [IN_W-1:0] re;
    logic signed [IN_W-1:0] im;
  } phasor_in_t;

  typedef struct packed {
    logic signed [OUT_W-1:0] re;
    logic signed [OUT_W-1:0] im;
  } phasor_out_t;

  typedef phasor_in_t  [NPH-1:0] wdg_in_t;
  typedef phasor_out_t [NPH-1:0] wdg_out_t;
  typedef wdg_in_t     [NW-1:0]  all_in_t;
  typedef wdg_out_t    [NW-1:0]  all_out_t;

  typedef struct packed {
    logic              gnd;
    logic [1:0]        conn;
    logic [CODE_W-1:0] code;
  } wcfg_t;

endpackage

// file: hdl/phase_mix.sv
`timescale 1ns/1ps
`default_nettype none
module phase_mix
  import wpc_pkg::*;
(
  input  wire wdg_in_t           x,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              gnd_in_zone,
  output var  wdg_out_t          y
);

  // even code: one phase, rotated and maybe negated
  function automatic logic signed [IN_W:0] pick(
    input logic [CODE_W-1:0]     e,
    input logic signed [IN_W-1:0] x0,
    input logic signed [IN_W-1:0] x1,
    input logic signed [IN_W-1:0] x2);
    logic signed [IN_W:0] v;
    case (e)
      4'h4, 4'ha: v = (IN_W+1)'(x1);
      4'h2, 4'h8: v = (IN_W+1)'(x2);
      default:    v = (IN_W+1)'(x0);
    endcase
    return e[1] ? -v : v;
  endfunction

  function automatic logic signed [OUT_W-1:0] mix(
    input logic [CODE_W-1:0]      c,
    input logic                   g,
    input logic signed [IN_W-1:0] x0,
    input logic signed [IN_W-1:0] x1,
    input logic signed [IN_W-1:0] x2);
    logic [CODE_W-1:0]        lo;
    logic [CODE_W-1:0]        hi;
    logic signed [SUM_W-1:0]  acc;
    logic signed [PROD_W-1:0] prod;
    logic signed [SUM_W-1:0]  e0;
    lo   = c - 4'h1;
    hi   = (c == LAST_CODE) ? '0 : c + 4'h1;
    e0   = SUM_W'(pick(c, x0, x1, x2));
    acc  = '0;
    prod = '0;
    if (c[0]) begin
      // odd code: sum of the two neighbour shifts scaled 1/sqrt3
      acc  = SUM_W'(pick(lo, x0, x1, x2)) + SUM_W'(pick(hi, x0, x1, x2));
      prod = PROD_W'(acc) * PROD_W'(INV_SQRT3);
      return OUT_W'(prod >>> FRAC);
    end else if (g) begin
      // zero sequence third is taken with the shift's sign
      acc  = SUM_W'(x0) + SUM_W'(x1) + SUM_W'(x2);
      prod = PROD_W'(acc) * PROD_W'(ONE_THIRD);
      if (c[1]) begin
        return OUT_W'(e0 + SUM_W'(prod >>> FRAC));
      end
      return OUT_W'(e0 - SUM_W'(prod >>> FRAC));
    end
    return OUT_W'(e0);
  endfunction

  // one combiner per phase, inputs rotated so phase k is x0
  for (genvar k = 0; k < NPH; k++) begin : g_ph
    localparam int K1 = (k + 1) % NPH;
    localparam int K2 = (k + 2) % NPH;
    assign y[k].re = mix(code, gnd_in_zone, x[k].re, x[K1].re, x[K2].re);
    assign y[k].im = mix(code, gnd_in_zone, x[k].im, x[K1].im, x[K2].im);
  end

endmodule
`default_nettype wire

// file: tb/wpc_src.sv
`timescale 1ns/1ps
`default_nettype none
module wpc_src
  import wpc_pkg::*;
(
  input  wire logic    hclk,
  input  wire logic    go,
  input  wire all_in_t smp,
  output var  logic    in_valid,
  output var  all_in_t in_data
);
  // one sample per cycle while go; idle data is inverted so stale values never look valid
  always @(posedge hclk) begin
    in_valid <= go;
    in_data  <= go ? smp : ~smp;
  end
endmodule
`default_nettype wire

// file: tb/wpc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wpc_asserts
  import wpc_pkg::*;
(
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic             in_valid,
  input wire all_in_t          in_data,
  input wire logic             out_valid,
  input wire all_out_t         out_data,
  input wire logic [REF_W-1:0] ref_wdg
);
  logic             wr_r;
  logic [7:0]       wa_r;
  logic             en_r;
  wcfg_t [NW-1:0]   cfg_r;
  logic [REF_W-1:0] ref_x;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // address phase of a write, held for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      wa_r <= 8'h00;
    end else if (hready) begin
      wr_r <= hsel & htrans[1] & hwrite;
      wa_r <= haddr[7:0];
    end
  end
  // shadow of settings; out-of-range codes are dropped like the design does
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r  <= EN_RST;
      cfg_r <= '0;
    end else if (wr_r && hready) begin
      if (wa_r == CTRL_OFS) en_r <= hwdata[CTRL_EN];
      for (int w = 0; w < NW; w++) begin
        if (wa_r == WCFG_OFS + WCFG_STEP * w && hwdata[3:0] <= LAST_CODE) cfg_r[w] <= wcfg_t'(hwdata[6:0]);
      end
    end
  end
  // lowest non-wye winding wins, winding one otherwise
  always_comb begin
    ref_x = '0;
    for (int w = NW - 1; w >= 0; w--) begin
      if (cfg_r[w].conn != CONN_WYE) ref_x = REF_W'(w);
    end
  end
  function automatic wdg_out_t ext(wdg_in_t x);
    for (int p = 0; p < NPH; p++) begin
      ext[p].re = OUT_W'(x[p].re);
      ext[p].im = OUT_W'(x[p].im);
    end
  endfunction
  chk_valid_latency: assert property (
    out_valid == $past(in_valid && en_r, 2)) else $error("strobe not two cycles after accepted sample");
  chk_strobe_single: assert property (
    out_valid && !$past(in_valid) |=> !out_valid) else $error("strobe longer than one cycle");
  chk_data_hold: assert property (
    !out_valid |-> $stable(out_data)) else $error("output data moved without strobe");
  chk_zero_through: assert property (
    in_valid && en_r && in_data == '0 |-> ##2 out_data == '0) else $error("zero input gave nonzero output");
  chk_ref_select: assert property (
    ref_wdg == $past(ref_x)) else $error("wrong reference winding");
  chk_ref_unrotated: assert property (
    out_valid && !$past(cfg_r[ref_wdg].gnd, 2) |-> out_data[$past(ref_wdg, 2)] == $past(ext(in_data[ref_wdg]), 2))
    else $error("reference winding was altered");
  chk_rdata_load: assert property (
    $changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready)) else $error("read data changed unasked");
  chk_bus_okay: assert property (
    $past(hresetn) |-> hreadyout && !hresp) else $error("bus stalled or answered with error");
endmodule
bind winding_phase_compensator wpc_asserts i_wpc_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid), .in_data(in_data), .out_valid(out_valid),
  .out_data(out_data), .ref_wdg(ref_wdg));
`default_nettype wire

// file: tb/tb_winding_phase_compensator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_winding_phase_compensator
  import wpc_pkg::*;
;
  logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [31:0]      haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]       htrans = HTRANS_IDLE;
  logic             hreadyout, hresp, out_valid, in_valid;
  logic [REF_W-1:0] ref_wdg;
  all_in_t          smp = '0, in_data;
  all_out_t         out_data;
  all_out_t         q[$];
  wcfg_t [NW-1:0]   cfg_m = '0;
  bit               rot_m = 1'b0, en_m = 1'b1;
  int               fail_count = 0, checks_done = 0, cnt_m = 0;
  logic [7:0]       ra[5] = '{CTRL_OFS, STAT_OFS, CNT_OFS, WCFG_OFS, 8'h40};
  logic [31:0]      rv[5] = '{32'h2, 32'h4, 32'h0, 32'h0, 32'h0};
  initial forever #25 hclk = ~hclk;
  winding_phase_compensator i_winding_phase_compensator (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid), .in_data(in_data),
    .out_valid(out_valid), .out_data(out_data), .ref_wdg(ref_wdg));
  wpc_src i_wpc_src (.hclk(hclk), .go(go), .smp(smp), .in_valid(in_valid), .in_data(in_data));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string n, logic [35:0] seen, logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // bounded wait for the slave; a stuck bus ends the run
  task automatic ready();
    for (int n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    fail_count++;
    finish_test();
  endtask
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    ready();
    htrans <= HTRANS_IDLE;
    hsel   <= 1'b0;
    hwdata <= d;
    ready();
    rd = hrdata;
  endtask
  // phase e steps from phase k, negated on the 60 degree odd thirds
  function automatic int xv(wdg_in_t x, int e, int k, bit im);
    int v;
    v = im ? x[(k + e % 3) % 3].im : x[(k + e % 3) % 3].re;
    return e % 4 == 2 ? -v : v;
  endfunction
  function automatic int pv(wdg_in_t x, int c, bit g, int k, bit im);
    int s;
    s = xv(x, 0, k, im) + xv(x, 4, k, im) + xv(x, 8, k, im); // steps 4 and 8 reach b and c unnegated
    s = (s * ONE_THIRD) >>> 15;
    if (c % 2) return ((xv(x, c - 1, k, im) + xv(x, (c + 1) % 12, k, im)) * INV_SQRT3) >>> 15;
    return xv(x, c, k, im) + (!g ? 0 : c % 4 == 0 ? -s : s);
  endfunction
  function automatic int mref();
    mref = 0;
    for (int w = NW - 1; w >= 0; w--) if (cfg_m[w].conn != CONN_WYE) mref = w;
  endfunction
  function automatic int code(int w);
    int d;
    d = int'(cfg_m[mref()].code) - int'(cfg_m[w].code);
    return ((rot_m ? -d : d) + 12) % 12;
  endfunction
  function automatic logic [31:0] stat();
    stat = 32'(mref());
    stat[STAT_ALLWYE] = mref() == 0 && cfg_m[0].conn == CONN_WYE;
    for (int w = 0; w < NW; w++) stat[STAT_CODES + 4 * w +: 4] = 4'(code(w));
  endfunction
  function automatic all_out_t model(all_in_t x);
    for (int w = 0; w < NW; w++)
      for (int k = 0; k < NPH; k++)
        model[w][k] = {OUT_W'(pv(x[w], code(w), cfg_m[w].gnd, k, 0)), OUT_W'(pv(x[w], code(w), cfg_m[w].gnd, k, 1))};
  endfunction
  // expected results queued at acceptance, compared at each strobe
  always @(posedge hclk) begin
    all_out_t e;
    if (in_valid === 1'b1 && en_m) begin
      q.push_back(model(in_data));
      cnt_m++;
    end
    if (out_valid === 1'b1 && q.size() == 0) check("extra strobe", 36'h1, 36'h0);
    else if (out_valid === 1'b1) begin
      e = q.pop_front();
      for (int w = 0; w < NW; w++)
        for (int k = 0; k < NPH; k++) check("out_data", out_data[w][k], e[w][k]);
    end
  end
  // a burst of back-to-back samples, then a fixed wait past the two-cycle latency
  task automatic burst(int n, bit z);
    repeat (n) begin
      @(posedge hclk);
      go <= 1'b1;
      for (int w = 0; w < NW; w++) for (int k = 0; k < NPH; k++) smp[w][k] <= z ? '0 : phasor_in_t'($urandom);
    end
    @(posedge hclk);
    go <= 1'b0;
    repeat (6) @(posedge hclk);
    check("pending", q.size(), 0);
  endtask
  initial begin
    void'($urandom(32'h5048f1d6));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      bus(ra[i], 1'b0, '0);
      check("reset read", rd, rv[i]);
    end
    for (int t = 0; t < 48; t++) begin
      for (int w = 0; w < NW; w++) begin
        cfg_m[w].code = 4'($urandom % 12);
        cfg_m[w].conn = t % 4 == 0 ? CONN_WYE : 2'($urandom);
        cfg_m[w].gnd  = 1'($urandom);
        bus(8'(WCFG_OFS + WCFG_STEP * w), 1'b1, 32'(cfg_m[w]));
      end
      rot_m = 1'($urandom);
      bus(CTRL_OFS, 1'b1, {30'h0, 1'b1, rot_m});
      bus(STAT_OFS, 1'b0, '0);
      check("status", rd, stat());
      check("ref_wdg", ref_wdg, 36'(mref()));
      burst(3, t % 8 == 0);
    end
    // disabled stream drops samples silently
    bus(CTRL_OFS, 1'b1, 32'h0);
    en_m = 1'b0;
    burst(2, 1'b0);
    bus(CTRL_OFS, 1'b1, 32'h2);
    en_m = 1'b1;
    // an angle code past eleven is refused and flagged until cleared
    bus(WCFG_OFS, 1'b1, 32'(NCODE));
    bus(WCFG_OFS, 1'b0, '0);
    check("wcfg kept", rd, 32'(cfg_m[0]));
    bus(STAT_OFS, 1'b0, '0);
    check("status err", rd, stat() | 32'h1 << STAT_ERR);
    bus(STAT_OFS, 1'b1, 32'h1 << STAT_ERR);
    bus(STAT_OFS, 1'b0, '0);
    check("status clr", rd, stat());
    bus(CNT_OFS, 1'b0, '0);
    check("count", rd, 32'(cnt_m));
    finish_test();
  end
endmodule
`default_nettype wire
